// ===== rtl/htx_pkg.sv
// Operation
// - Swing field at bits 5:4: 00 180 mV, 01 200 mV, 1x 220 mV.
// - Swing loads from straps at reset; software may overwrite later.
// - Pre-emphasis field at bits 1:0: 00 1.5 dB, 01 0 dB, 1x 2.5 dB.
// - Pre-emphasis loads from strap one at reset: high gives 1x, else 01.
// - Timeout limit low byte is read-write at index 0x10.
// - Timeout limit high byte is read-write at index 0x11.
// - Both timeout limit bytes reset to 0xff.
// - A turnaround request restarts the timeout counter from zero.
// - A turnaround acknowledge without a same-cycle request stops the timeout counter at once.
// - Far side must acknowledge in time; on expiry the turnaround aborts.
// - The timeout counter advances only on the low-power transmit clock.
package htx_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] HTX_IDX_SWING_PREEMPH = 8'h0e;
    localparam logic [7:0] HTX_IDX_LIMIT_LOW = 8'h10;
    localparam logic [7:0] HTX_IDX_LIMIT_HIGH = 8'h11;
    localparam logic [7:0] HTX_IDX_STATUS = 8'h12;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int HTX_SWING_LSB = 4;
    localparam int HTX_PREEMPH_LSB = 0;
    localparam logic [7:0] HTX_LIMIT_RESET = 8'hff;
    localparam int HTX_STAT_ACTIVE_BIT = 0;
    localparam int HTX_STAT_EXPIRED_BIT = 1;

    // ****************************************************************
    // Level codes
    // ****************************************************************
    localparam logic [1:0] HTX_STRAP_LOW = 2'h0;
    localparam logic [1:0] HTX_STRAP_MID = 2'h1;
    localparam logic [1:0] HTX_STRAP_HIGH = 2'h2;
    localparam logic [1:0] HTX_SWING_180 = 2'h0;
    localparam logic [1:0] HTX_SWING_200 = 2'h1;
    localparam logic [1:0] HTX_SWING_220 = 2'h2;
    localparam logic [1:0] HTX_PRE_1P5 = 2'h0;
    localparam logic [1:0] HTX_PRE_0 = 2'h1;
    localparam logic [1:0] HTX_PRE_2P5 = 2'h2;

    // Turnaround timer states
    typedef enum logic [1:0] {HTX_IDLE, HTX_COUNT, HTX_EXPIRED} htx_ta_type;

endpackage

// ===== rtl/htx_regs.sv
module htx_regs
    import htx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] strap_pin_zero,
    input wire logic [1:0] strap_pin_one,
    input wire logic lptx_clk,
    input wire logic turnaround_req,
    input wire logic turnaround_ack,
    output logic [1:0] hs_swing_level,
    output logic [1:0] hs_preemph_level,
    output logic turnaround_active,
    output logic turnaround_abort
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0] swing_r, swing_nxt;
    logic [1:0] preemph_r, preemph_nxt;
    logic [7:0] lim_lo_r, lim_lo_nxt;
    logic [7:0] lim_hi_r, lim_hi_nxt;
    logic straps_done_r, straps_done_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [7:0] idx;
    logic mapped;
    logic wr_fire;
    logic [1:0] strap_swing;
    logic [1:0] strap_preemph;
    logic [7:0] swpe_view;
    logic sel_swpe;
    logic sel_lo;
    logic sel_hi;
    logic sel_stat;

    // ****************************************************************
    // Turnaround timer state
    // ****************************************************************
    htx_ta_type ta_r, ta_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic lptx_prev_r, lptx_prev_nxt;
    logic abort_r, abort_nxt;
    logic active_r, active_nxt;
    logic lptx_rise;
    logic [15:0] limit;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Word index; byte address is four times the index
    assign idx = paddr[9:2];

    // One select per implemented word
    assign sel_swpe = (idx == HTX_IDX_SWING_PREEMPH);
    assign sel_lo = (idx == HTX_IDX_LIMIT_LOW);
    assign sel_hi = (idx == HTX_IDX_LIMIT_HIGH);
    assign sel_stat = (idx == HTX_IDX_STATUS);

    // Anything else, or a misaligned address, answers with an error
    assign mapped = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) &&
                    (sel_swpe || sel_lo || sel_hi || sel_stat);

    // Write lands at the completing edge, low byte lane only
    assign wr_fire = psel && penable && pready_r && pwrite && mapped && pstrb[0];

    // Full 16-bit limit seen by the timer
    assign limit = {lim_hi_r, lim_lo_r};

    // Slow clock sampled as data: a rise is high now, low one edge ago
    assign lptx_rise = lptx_clk && !lptx_prev_r;

    // Transmit settings view, reserved bits held at zero
    // reserved read zero
    assign swpe_view = {2'h0, swing_r, 2'h0, preemph_r};

    // ****************************************************************
    // Strap decode
    // ****************************************************************
    // Straps are three-level: low, mid, high; the unused code 11 is
    // treated like mid, so a floating or odd strap never picks the
    // strongest setting. The board keeps the straps steady after reset
    // release, so the first clock edge takes a settled value.

    // Strap decode for swing
    // strap swing decode
    always_comb begin
        if (strap_pin_zero == HTX_STRAP_HIGH) begin
            strap_swing = HTX_SWING_220;
        end else if (strap_pin_zero == HTX_STRAP_LOW &&
                     strap_pin_one == HTX_STRAP_HIGH) begin
            strap_swing = HTX_SWING_220;
        end else begin
            strap_swing = HTX_SWING_200;
        end
    end

    // Strap decode for pre-emphasis
    // strap preemph decode
    always_comb begin
        if (strap_pin_one == HTX_STRAP_HIGH) begin
            strap_preemph = HTX_PRE_2P5;
        end else begin
            strap_preemph = HTX_PRE_0;
        end
    end

    // ****************************************************************
    // Register file next state
    // ****************************************************************
    always_comb begin
        swing_nxt = swing_r;
        preemph_nxt = preemph_r;
        lim_lo_nxt = lim_lo_r;
        lim_hi_nxt = lim_hi_r;
        straps_done_nxt = 1'b1;
        if (!straps_done_r) begin
            swing_nxt = strap_swing;
            preemph_nxt = strap_preemph;
        end else if (wr_fire && pstrb[0]) begin
            case (idx)
                HTX_IDX_SWING_PREEMPH: begin
                    swing_nxt = pwdata[HTX_SWING_LSB +: 2];
                    preemph_nxt = pwdata[HTX_PREEMPH_LSB +: 2];
                end
                HTX_IDX_LIMIT_LOW: lim_lo_nxt = pwdata[7:0];
                HTX_IDX_LIMIT_HIGH: lim_hi_nxt = pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // APB answer: ready one cycle into the access phase
    // ****************************************************************
    always_comb begin
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        // Answer one edge into the access phase, never twice in a row
        if (psel && penable && !pready_r) begin
            pready_nxt = 1'b1;
            // Unmapped or misaligned: error pulse and zero data
            pslverr_nxt = !mapped;
            prdata_nxt = 32'h0;
            if (!pwrite && mapped) begin
                case (idx)
                    HTX_IDX_SWING_PREEMPH: prdata_nxt = {24'h0, swpe_view};
                    HTX_IDX_LIMIT_LOW: prdata_nxt = {24'h0, lim_lo_r};
                    HTX_IDX_LIMIT_HIGH: prdata_nxt = {24'h0, lim_hi_r};
                    HTX_IDX_STATUS: begin
                        prdata_nxt[HTX_STAT_ACTIVE_BIT] = active_r;
                        prdata_nxt[HTX_STAT_EXPIRED_BIT] = (ta_r == HTX_EXPIRED);
                    end
                    default: prdata_nxt = 32'h0;
                endcase
            end
        end
    end

    // Register file flops; swing and pre-emphasis hold mid codes until
    // the first edge after reset release, when the straps are taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swing_r <= HTX_SWING_200;
            preemph_r <= HTX_PRE_0;
            lim_lo_r <= HTX_LIMIT_RESET;
            lim_hi_r <= HTX_LIMIT_RESET;
            straps_done_r <= 1'b0;
        end else begin
            swing_r <= swing_nxt;
            preemph_r <= preemph_nxt;
            lim_lo_r <= lim_lo_nxt;
            lim_hi_r <= lim_hi_nxt;
            straps_done_r <= straps_done_nxt;
        end
    end

    // ****************************************************************
    // APB answer flops
    // ****************************************************************
    // Ready, error and read data are registered together, so the
    // answer stands for exactly one cycle and read data then holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ****************************************************************
    // Turnaround timeout timer
    // ****************************************************************
    // The slow clock is seen only through its rising edge, so a slow
    // clock that stops simply freezes the count.
    // A request wins over an acknowledge in the same cycle, so a fresh
    // turnaround always restarts from zero.
    // The count stops at the limit and never wraps: a limit of zero
    // aborts at the first slow rise, 0xffff still ends in time.
    // An acknowledge while not counting is ignored.
    always_comb begin
        ta_nxt = ta_r;
        cnt_nxt = cnt_r;
        abort_nxt = 1'b0;
        lptx_prev_nxt = lptx_clk;
        if (turnaround_req) begin
            ta_nxt = HTX_COUNT;
            cnt_nxt = 16'h0;
        end else begin
            case (ta_r)
                HTX_COUNT: begin
                    if (turnaround_ack) begin
                        ta_nxt = HTX_IDLE;
                    end else if (lptx_rise) begin
                        if (cnt_r >= limit) begin
                            ta_nxt = HTX_EXPIRED;
                            abort_nxt = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r + 16'h1;
                        end
                    end
                end
                HTX_IDLE: ta_nxt = HTX_IDLE;
                HTX_EXPIRED: ta_nxt = HTX_EXPIRED;
                default: ta_nxt = HTX_IDLE;
            endcase
        end
        active_nxt = (ta_nxt == HTX_COUNT);
    end

    // Timer flops; the abort pulse and the drop of active share an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_r <= HTX_IDLE;
            cnt_r <= 16'h0;
            abort_r <= 1'b0;
            active_r <= 1'b0;
            lptx_prev_r <= 1'b0;
        end else begin
            ta_r <= ta_nxt;
            cnt_r <= cnt_nxt;
            abort_r <= abort_nxt;
            active_r <= active_nxt;
            lptx_prev_r <= lptx_prev_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output comes straight from a flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign hs_swing_level = swing_r;
    assign hs_preemph_level = preemph_r;
    assign turnaround_active = active_r;
    assign turnaround_abort = abort_r;

endmodule

// ===== tb/htx_regs_monitor.sv
module htx_regs_monitor
    import htx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic lptx_clk,
    input wire logic turnaround_req,
    input wire logic turnaround_ack,
    input wire logic [1:0] hs_swing_level,
    input wire logic [1:0] hs_preemph_level,
    input wire logic turnaround_active,
    input wire logic turnaround_abort
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ADDR_TX = {22'h0, HTX_IDX_SWING_PREEMPH, 2'h0};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write of the transmit settings word
    sequence s_tx_wr;
        pready && pwrite && pstrb[0] && paddr == ADDR_TX;
    endsequence
    AST_SWING_WR: assert property (s_tx_wr |=> hs_swing_level == $past(pwdata[5:4]))
        else $error("swing field not written");
    AST_PRE_WR: assert property (s_tx_wr |=> hs_preemph_level == $past(pwdata[1:0]))
        else $error("pre-emphasis field not written");
    AST_RSVD_ZERO: assert property (pready && !pwrite && paddr == ADDR_TX |->
        prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0 && prdata[5:4] == hs_swing_level)
        else $error("settings read wrong");
    AST_REQ_START: assert property (turnaround_req |=> turnaround_active)
        else $error("request did not start timer");
    AST_ACK_STOP: assert property (turnaround_active && turnaround_ack && !turnaround_req
        |=> !turnaround_active) else $error("acknowledge did not stop timer");
    AST_ABORT_PULSE: assert property (turnaround_abort |=> !turnaround_abort)
        else $error("abort longer than one cycle");
    AST_ABORT_ENDS: assert property (turnaround_abort |-> !turnaround_active
        && $past(turnaround_active)) else $error("abort without running timer");
    AST_LP_CLOCK: assert property (turnaround_abort |-> $past(lptx_clk))
        else $error("abort not after slow clock edge");
endmodule

bind htx_regs htx_regs_monitor i_mon (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .lptx_clk(lptx_clk),
    .turnaround_req(turnaround_req), .turnaround_ack(turnaround_ack),
    .hs_swing_level(hs_swing_level), .hs_preemph_level(hs_preemph_level),
    .turnaround_active(turnaround_active), .turnaround_abort(turnaround_abort));

// ===== tb/htx_far_model.sv
module htx_far_model (
    input wire logic pclk,
    output logic lptx_clk = 1'b0,
    output logic turnaround_req = 1'b0,
    output logic turnaround_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic handshake(input bit ack);
        @(posedge pclk);
        if (ack) turnaround_ack <= 1'b1;
        else turnaround_req <= 1'b1;
        @(posedge pclk);
        turnaround_ack <= 1'b0;
        turnaround_req <= 1'b0;
    endtask
    // slow clock bursts, idle low between them
    task automatic lp_pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            lptx_clk <= 1'b1;
            repeat (2) @(posedge pclk);
            lptx_clk <= 1'b0;
            @(posedge pclk);
        end
    endtask
endmodule

// ===== tb/htx_regs_tb.sv
module htx_regs_tb
    import htx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, lptx_clk, t_req, t_ack, t_act, t_abort, perr, hi;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [1:0] sz = 2'h0, so = 2'h0, swing, pre;
    logic [3:0] ps = 4'hf;
    logic [1:0] zs[4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    logic [1:0] os[4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    int mismatches = 0, comparisons = 0, aborts = 0;
    // Device and far-side partner
    htx_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(ps), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_pin_zero(sz), .strap_pin_one(so),
        .lptx_clk(lptx_clk), .turnaround_req(t_req), .turnaround_ack(t_ack),
        .hs_swing_level(swing), .hs_preemph_level(pre), .turnaround_active(t_act),
        .turnaround_abort(t_abort));
    htx_far_model i_far (.pclk(pclk), .lptx_clk(lptx_clk), .turnaround_req(t_req),
        .turnaround_ack(t_ack));
    // Clock and abort counter
    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) if (t_abort === 1'b1) aborts++;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) mismatches++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // Verdict
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1ms;
        mismatches++;
        tally_and_finish();
    end
    // Tests
    initial begin
        foreach (zs[i]) begin
            presetn <= 1'b0;
            sz <= zs[i];
            so <= os[i];
            repeat (16) @(posedge pclk);
            presetn <= 1'b1;
            hi = zs[i] == HTX_STRAP_HIGH || (zs[i] == HTX_STRAP_LOW && os[i] == HTX_STRAP_HIGH);
            rchk(HTX_IDX_SWING_PREEMPH, {26'h0, hi ? HTX_SWING_220 : HTX_SWING_200, 2'h0,
                os[i] == HTX_STRAP_HIGH ? HTX_PRE_2P5 : HTX_PRE_0});
        end
        rchk(HTX_IDX_LIMIT_LOW, {24'h0, HTX_LIMIT_RESET});
        rchk(HTX_IDX_LIMIT_HIGH, {24'h0, HTX_LIMIT_RESET});
        $display("test strap_reset done");
        apb(1'b1, HTX_IDX_SWING_PREEMPH, 32'hff);
        rchk(HTX_IDX_SWING_PREEMPH, 32'h33);
        chk({28'h0, swing, pre}, 32'hf);
        apb(1'b1, HTX_IDX_SWING_PREEMPH, 32'h10);
        rchk(HTX_IDX_SWING_PREEMPH, 32'h10);
        chk({28'h0, swing, pre}, 32'h4);
        apb(1'b1, HTX_IDX_LIMIT_LOW, 32'h103);
        apb(1'b1, HTX_IDX_LIMIT_HIGH, 32'h0);
        rchk(HTX_IDX_LIMIT_LOW, 32'h3);
        rchk(HTX_IDX_LIMIT_HIGH, 32'h0);
        ps <= 4'he;
        apb(1'b1, HTX_IDX_LIMIT_HIGH, 32'h55);
        ps <= 4'hf;
        rchk(HTX_IDX_LIMIT_HIGH, 32'h0);
        rchk(8'h14, 32'h0);
        chk({31'h0, perr}, 32'h1);
        $display("test registers done");
        i_far.handshake(1'b0);
        i_far.lp_pulses(3);
        chk({31'h0, t_act}, 32'h1);
        i_far.lp_pulses(1);
        chk(aborts, 32'h1);
        rchk(HTX_IDX_STATUS, 32'h2);
        i_far.handshake(1'b0);
        i_far.lp_pulses(3);
        i_far.handshake(1'b0);
        i_far.lp_pulses(3);
        chk(aborts, 32'h1);
        repeat (40) @(posedge pclk);
        chk({31'h0, t_act}, 32'h1);
        rchk(HTX_IDX_STATUS, 32'h1);
        i_far.handshake(1'b1);
        i_far.lp_pulses(4);
        chk({aborts[30:0], t_act}, 32'h2);
        rchk(HTX_IDX_STATUS, 32'h0);
        $display("test turnaround done");
        tally_and_finish();
    end
endmodule
